// File: verilog/msrta_pkg.sv
// constants and types shared by the routed-message and typed-access interpreter
// Functional notes
// - routed request: code 0x40, port, subnode, header
// - response echoes code, source port/subnode, crc last; code relays remote bytes as received, then crc
// - own node, port zero: process locally
// - nonzero port: forward, do not process; code answers ports above 3 with exception 2
// - ports 1 to 3 select option slots
// - subnode zero at downstream: process and answer
// - nonzero subnode: send embedded message onward
// - wrap remote reply into full response frame
// - address bits 15-14 select data type
// - type from start address covers whole block
// - 32-bit values as two registers, MSW first
// - 32-bit integer adds 0x4000 to register base
// - odd count on 32-bit access: exception 2
// - exception: code with bit 7 set, code byte
// - crc16 0xa001 reflected, low byte first
`default_nettype none
package msrta_pkg;
    localparam logic [7:0] MSRTA_FC_ROUTED = 8'h40;
    localparam logic [7:0] MSRTA_FC_READ = 8'h03;
    localparam logic [7:0] MSRTA_FC_WRITE = 8'h10;
    localparam logic [7:0] MSRTA_FC_RDWR = 8'h17;
    localparam logic [7:0] MSRTA_EXC_FLAG = 8'h80;
    localparam logic [7:0] MSRTA_EXC_FUNC = 8'h01;
    localparam logic [7:0] MSRTA_EXC_RANGE = 8'h02;
    localparam logic [7:0] MSRTA_GLOBAL_NODE = 8'h00;
    localparam logic [7:0] MSRTA_MAX_NODE = 8'hf7;
    localparam logic [15:0] MSRTA_CRC_POLY = 16'ha001;
    localparam logic [15:0] MSRTA_CRC_INIT = 16'hffff;
    localparam logic [15:0] MSRTA_INT32_OFFSET = 16'h4000;
    localparam logic [7:0] MSRTA_IDX_NODE = 8'h00;
    localparam logic [7:0] MSRTA_IDX_FUNC = 8'h01;
    localparam logic [7:0] MSRTA_IDX_PORT = 8'h02;
    localparam logic [7:0] MSRTA_IDX_SUB = 8'h03;
    localparam logic [7:0] MSRTA_IDX_ADDR_HI = 8'h02;
    localparam logic [7:0] MSRTA_IDX_ADDR_LO = 8'h03;
    localparam logic [7:0] MSRTA_IDX_CNT_HI = 8'h04;
    localparam logic [7:0] MSRTA_IDX_CNT_LO = 8'h05;
    localparam logic [7:0] MSRTA_IDX_PAYLOAD = 8'h07;
    localparam logic [1:0] MSRTA_NUM_SLOTS = 2'h3;
    typedef enum logic [1:0]
    {
        MSRTA_TYPE_INT16 = 2'h0,
        MSRTA_TYPE_INT32 = 2'h1,
        MSRTA_TYPE_FLOAT = 2'h2,
        MSRTA_TYPE_RSVD = 2'h3
    } msrta_dtype_type;
    typedef enum logic [6:0]
    {
        MSRTA_ST_RECV = 7'h01,
        MSRTA_ST_CHECK = 7'h02,
        MSRTA_ST_EXC = 7'h04,
        MSRTA_ST_CRC_LO = 7'h08,
        MSRTA_ST_CRC_HI = 7'h10,
        MSRTA_ST_PASS = 7'h20,
        MSRTA_ST_DONE = 7'h40
    } msrta_state_type;
endpackage : msrta_pkg
`default_nettype wire

// File: verilog/msrta_crc_if.sv
// byte stream carrier between the interpreter and its crc engine
`default_nettype none
interface msrta_crc_if;
    logic clear;
    logic valid;
    logic [7:0] data;
    logic [15:0] crc;
    modport user (output clear, output valid, output data, input crc);
    modport engine (input clear, input valid, input data, output crc);
endinterface : msrta_crc_if
`default_nettype wire

// File: verilog/msrta_crc16.sv
// crc16 engine, one byte per clock, reflected polynomial
`default_nettype none
module msrta_crc16
    import msrta_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    msrta_crc_if.engine bus
);
    typedef struct packed
    {
        logic [15:0] crc;
    } msrta_crc_state_type;
    msrta_crc_state_type state;
    msrta_crc_state_type next_state;
    logic [15:0] work;

    // eight serial steps unrolled by the loop, still one clock per byte
    always_comb
    begin
        work = state.crc ^ {8'h00, bus.data};
        for (int i = 0; i < 8; i++)
        begin
            work = work[0] ? ((work >> 1) ^ MSRTA_CRC_POLY) : (work >> 1);
        end
        next_state = state;
        if (bus.clear)
        begin
            next_state.crc = MSRTA_CRC_INIT;
        end
        else if (bus.valid)
        begin
            next_state.crc = work;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= '{crc: MSRTA_CRC_INIT};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign bus.crc = state.crc;

    AST_CRC_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst)
        bus.clear |=> bus.crc == MSRTA_CRC_INIT)
        else $error("crc not reset after clear");
endmodule : msrta_crc16
`default_nettype wire

// File: verilog/msrta_core.sv
// routed-message and typed-access request interpreter, top module
`default_nettype none
module msrta_core
    import msrta_pkg::*;
#(
    parameter logic [7:0] SOURCE_PORT = 8'h00,
    parameter bit FLOAT_SUPPORT = 1'b1
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] own_node,
    input wire logic downstream_mode,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_end,
    input wire logic rx_crc_ok,
    input wire logic [7:0] remote_data,
    input wire logic remote_valid,
    input wire logic remote_end,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    output logic [7:0] fwd_data,
    output logic fwd_valid,
    output logic fwd_last,
    output logic [1:0] fwd_slot,
    output logic [7:0] net_data,
    output logic net_valid,
    output logic net_last,
    output logic [7:0] net_node,
    output logic local_req,
    output logic [1:0] access_type,
    output logic [15:0] access_base,
    output logic [15:0] access_count,
    output logic access_wide
);
    typedef struct packed
    {
        msrta_state_type st;
        logic [7:0] idx;
        logic [7:0] node;
        logic [7:0] func;
        logic [7:0] port;
        logic [7:0] sub;
        logic [7:0] addr_hi;
        logic [7:0] addr_lo;
        logic [7:0] cnt_hi;
        logic [7:0] cnt_lo;
        logic [7:0] exc_code;
        logic [1:0] exc_step;
        logic [15:0] hold;
        logic [7:0] tx_data;
        logic tx_valid;
        logic tx_last;
        logic [7:0] fwd_data;
        logic fwd_valid;
        logic fwd_last;
        logic [1:0] fwd_slot;
        logic [7:0] net_data;
        logic net_valid;
        logic net_last;
        logic [7:0] net_node;
        logic local_req;
        logic [1:0] access_type;
        logic [15:0] access_base;
        logic [15:0] access_count;
        logic access_wide;
    } msrta_core_state_type;

    msrta_core_state_type state;
    msrta_core_state_type next_state;
    msrta_crc_if crc_bus ();
    logic addressed;
    logic [15:0] start_addr;
    logic [15:0] reg_count;
    msrta_dtype_type dtype;
    logic remote_reply;

    msrta_crc16 u_crc (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .bus(crc_bus.engine)
    );

    // frame decode from captured header bytes
    assign addressed = (state.node == own_node);
    assign start_addr = {state.addr_hi, state.addr_lo};
    assign reg_count = {state.cnt_hi, state.cnt_lo};
    assign dtype = msrta_dtype_type'(start_addr[15:14]);
    assign remote_reply = downstream_mode && (state.st == MSRTA_ST_PASS);

    // crc runs over every byte sent back to the master except the two crc bytes
    always_comb
    begin
        crc_bus.clear = (state.st == MSRTA_ST_CHECK);
        crc_bus.valid = next_state.tx_valid && !next_state.tx_last && (next_state.st != MSRTA_ST_CRC_HI);
        crc_bus.data = next_state.tx_data;
    end

    always_comb
    begin
        next_state = state;
        next_state.tx_valid = 1'b0;
        next_state.tx_last = 1'b0;
        next_state.fwd_valid = 1'b0;
        next_state.fwd_last = 1'b0;
        next_state.net_valid = 1'b0;
        next_state.net_last = 1'b0;
        next_state.local_req = 1'b0;
        case (state.st)
            MSRTA_ST_RECV:
            begin
                // capture header fields by byte index
                if (rx_valid)
                begin
                    if (state.idx == MSRTA_IDX_NODE)
                        next_state.node = rx_data;
                    else if (state.idx == MSRTA_IDX_FUNC)
                        next_state.func = rx_data;
                    else if (state.idx == MSRTA_IDX_ADDR_HI)
                        next_state.addr_hi = rx_data;
                    else if (state.idx == MSRTA_IDX_ADDR_LO)
                        next_state.addr_lo = rx_data;
                    else if (state.idx == MSRTA_IDX_CNT_HI)
                        next_state.cnt_hi = rx_data;
                    else if (state.idx == MSRTA_IDX_CNT_LO)
                        next_state.cnt_lo = rx_data;
                    if (state.idx != 8'hff)
                        next_state.idx = state.idx + 8'h01;
                end
                if (rx_end)
                begin
                    next_state.port = state.addr_hi;
                    next_state.sub = state.addr_lo;
                    // corrupted frames are dropped silently, master times out
                    next_state.st = rx_crc_ok ? MSRTA_ST_CHECK : MSRTA_ST_DONE;
                end
            end
            MSRTA_ST_CHECK:
            begin
                next_state.exc_step = 2'h0;
                if (!addressed)
                begin
                    next_state.st = MSRTA_ST_DONE;
                end
                else if (state.func == MSRTA_FC_ROUTED)
                begin
                    next_state.idx = 8'h00;
                    if (!downstream_mode && state.port == 8'h00)
                    begin
                        next_state.local_req = 1'b1;
                        next_state.st = MSRTA_ST_DONE;
                    end
                    else if (!downstream_mode && state.port > {6'h00, MSRTA_NUM_SLOTS})
                    begin
                        next_state.exc_code = MSRTA_EXC_RANGE;
                        next_state.st = MSRTA_ST_EXC;
                    end
                    else if (!downstream_mode)
                    begin
                        next_state.fwd_slot = state.port[1:0];
                        next_state.st = MSRTA_ST_PASS;
                    end
                    else if (state.sub == 8'h00)
                    begin
                        next_state.local_req = 1'b1;
                        next_state.st = MSRTA_ST_DONE;
                    end
                    else
                    begin
                        next_state.net_node = state.sub;
                        next_state.st = MSRTA_ST_PASS;
                    end
                end
                else if (state.func == MSRTA_FC_READ || state.func == MSRTA_FC_WRITE || state.func == MSRTA_FC_RDWR)
                begin
                    if (dtype == MSRTA_TYPE_RSVD || (dtype == MSRTA_TYPE_FLOAT && !FLOAT_SUPPORT)
                        || (dtype != MSRTA_TYPE_INT16 && reg_count[0]))
                    begin
                        next_state.exc_code = MSRTA_EXC_RANGE;
                        next_state.st = MSRTA_ST_EXC;
                    end
                    else
                    begin
                        // one type for the whole block, base stripped of the type bits
                        next_state.access_type = dtype;
                        next_state.access_base = start_addr & ~(MSRTA_INT32_OFFSET << 1)
                            & ~MSRTA_INT32_OFFSET;
                        next_state.access_wide = (dtype != MSRTA_TYPE_INT16);
                        next_state.access_count = next_state.access_wide ? {1'b0, reg_count[15:1]} : reg_count;
                        next_state.local_req = 1'b1;
                        next_state.st = MSRTA_ST_DONE;
                    end
                end
                else
                begin
                    next_state.exc_code = MSRTA_EXC_FUNC;
                    next_state.st = MSRTA_ST_EXC;
                end
            end
            MSRTA_ST_EXC:
            begin
                // node, code with top bit, exception code
                next_state.tx_valid = 1'b1;
                next_state.exc_step = state.exc_step + 2'h1;
                if (state.exc_step == 2'h0)
                    next_state.tx_data = own_node;
                else if (state.exc_step == 2'h1)
                    next_state.tx_data = state.func | MSRTA_EXC_FLAG;
                else
                begin
                    next_state.tx_data = state.exc_code;
                    next_state.st = MSRTA_ST_CRC_LO;
                end
            end
            MSRTA_ST_PASS:
            begin
                // forwarding path: the frame bytes pass again from the receiver
                if (!downstream_mode)
                begin
                    next_state.fwd_valid = rx_valid;
                    next_state.fwd_data = rx_data;
                    next_state.fwd_last = rx_end;
                    if (rx_end)
                        next_state.st = MSRTA_ST_DONE;
                end
                else if (remote_valid || remote_end)
                begin
                    // remote reply bytes are relayed as received, only the crc is appended
                    next_state.tx_valid = remote_valid;
                    next_state.tx_data = remote_data;
                    if (remote_end)
                        next_state.st = MSRTA_ST_CRC_LO;
                end
                else
                begin
                    // node, function and trailing crc stay here: two bytes held back until the end is known
                    next_state.net_last = rx_end;
                    if (rx_valid)
                    begin
                        next_state.hold = {state.hold[7:0], rx_data};
                        next_state.net_valid = (state.idx >= 8'h04);
                        next_state.net_data = state.hold[15:8];
                        if (state.idx != 8'hff)
                            next_state.idx = state.idx + 8'h01;
                    end
                end
            end
            MSRTA_ST_CRC_LO:
            begin
                next_state.tx_valid = 1'b1;
                next_state.tx_data = crc_bus.crc[7:0];
                next_state.st = MSRTA_ST_CRC_HI;
            end
            MSRTA_ST_CRC_HI:
            begin
                next_state.tx_valid = 1'b1;
                next_state.tx_last = 1'b1;
                next_state.tx_data = crc_bus.crc[15:8];
                next_state.st = MSRTA_ST_DONE;
            end
            MSRTA_ST_DONE:
            begin
                next_state.idx = 8'h00;
                next_state.st = MSRTA_ST_RECV;
            end
            default:
            begin
                next_state.st = MSRTA_ST_RECV;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= '0;
            state.st <= MSRTA_ST_RECV;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign tx_data = state.tx_data;
    assign tx_valid = state.tx_valid;
    assign tx_last = state.tx_last;
    assign fwd_data = state.fwd_data;
    assign fwd_valid = state.fwd_valid;
    assign fwd_last = state.fwd_last;
    assign fwd_slot = state.fwd_slot;
    assign net_data = state.net_data;
    assign net_valid = state.net_valid;
    assign net_last = state.net_last;
    assign net_node = state.net_node;
    assign local_req = state.local_req;
    assign access_type = state.access_type;
    assign access_base = state.access_base;
    assign access_count = state.access_count;
    assign access_wide = state.access_wide;

    AST_NO_GLOBAL_REPLY: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state.st == MSRTA_ST_CHECK && state.node == MSRTA_GLOBAL_NODE && own_node != 8'h00)
        |=> state.st == MSRTA_ST_DONE)
        else $error("global frame answered");
    AST_PORT_ZERO_LOCAL: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state.st == MSRTA_ST_CHECK && addressed && state.func == MSRTA_FC_ROUTED
        && !downstream_mode && state.port == 8'h00) |=> local_req && !fwd_valid)
        else $error("port zero not local");
    AST_FORWARD: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state.st == MSRTA_ST_CHECK && addressed && state.func == MSRTA_FC_ROUTED && !downstream_mode
        && state.port != 8'h00 && state.port <= 8'h03) |=> !local_req && fwd_slot == $past(state.port[1:0]))
        else $error("nonzero port not forwarded");
    AST_SUB_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state.st == MSRTA_ST_CHECK && addressed && state.func == MSRTA_FC_ROUTED
        && downstream_mode && state.sub == 8'h00) |=> local_req)
        else $error("subnode zero not processed");
    AST_NET_NODE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state.st == MSRTA_ST_CHECK && addressed && state.func == MSRTA_FC_ROUTED
        && downstream_mode && state.sub != 8'h00) |=> net_node == $past(state.sub))
        else $error("wrong network node");
    AST_ODD_WIDE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state.st == MSRTA_ST_CHECK && addressed && state.func == MSRTA_FC_READ
        && start_addr[15:14] == 2'h1 && reg_count[0])
        |=> ##2 tx_valid && tx_data == (MSRTA_EXC_FLAG | MSRTA_FC_READ))
        else $error("odd wide count accepted");
    AST_EXC_CODE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state.st == MSRTA_ST_EXC && state.exc_step == 2'h2) |=> tx_data == $past(state.exc_code) ##2 tx_last)
        else $error("exception frame malformed");
    AST_WIDE_TYPE: assert property (@(posedge core_clk) disable iff (sys_rst)
        local_req && state.func == MSRTA_FC_READ |-> access_wide == (access_type != MSRTA_TYPE_INT16)
        && access_base[15:14] == 2'h0)
        else $error("typed access decode wrong");
    AST_WIDE_COUNT: assert property (@(posedge core_clk) disable iff (sys_rst)
        local_req && access_wide && state.func != MSRTA_FC_ROUTED |-> access_count == {1'b0, $past(reg_count[15:1])})
        else $error("wide count not halved");
    AST_CRC_ORDER: assert property (@(posedge core_clk) disable iff (sys_rst)
        state.st == MSRTA_ST_CRC_LO |=> tx_valid && !tx_last ##1 tx_valid && tx_last)
        else $error("crc bytes out of order");
    AST_REMOTE_WRAP: assert property (@(posedge core_clk) disable iff (sys_rst)
        remote_reply && remote_valid && !remote_end |=> tx_valid && tx_data == $past(remote_data))
        else $error("remote reply not relayed");
endmodule : msrta_core
`default_nettype wire

// File: sim/msrta_master_model.sv
// serial bus master model: frames requests, appends crc, gathers responses
`default_nettype none
module msrta_master_model
    import msrta_pkg::*;
(
    input wire logic core_clk,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_end,
    output logic rx_crc_ok,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] resp[$];
    int n_last;

    // reflected crc16, bit by bit, no table to keep it independent
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = MSRTA_CRC_INIT;
        foreach (b[i])
        begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++)
            begin
                c = c[0] ? ((c >> 1) ^ MSRTA_CRC_POLY) : (c >> 1);
            end
        end
        return c;
    endfunction : crc16

    // one byte per cycle, crc low byte first, bad crc on request
    task automatic send(input logic [7:0] f[$], input bit good);
        logic [15:0] c;
        c = crc16(f);
        if (!good)
        begin
            c = ~c;
        end
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i])
        begin
            @(negedge core_clk);
            rx_data = f[i];
            rx_valid = 1'b1;
        end
        @(negedge core_clk);
        rx_valid = 1'b0;
        rx_data = ~rx_data; // released line must not look like the last byte
        rx_end = 1'b1;
        rx_crc_ok = good;
        @(negedge core_clk);
        rx_end = 1'b0;
        rx_crc_ok = 1'b0;
    endtask : send

    initial
    begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_end = 1'b0;
        rx_crc_ok = 1'b0;
        n_last = 0;
    end

    // gather response bytes mid-cycle, away from the edge that launches them
    always @(negedge core_clk)
    begin
        if (tx_valid === 1'b1)
        begin
            resp.push_back(tx_data);
        end
        if (tx_last === 1'b1)
        begin
            n_last++;
        end
    end
endmodule : msrta_master_model
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the routed-message and typed-access interpreter
`default_nettype none
module tb
    import msrta_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst, downstream_mode, rx_valid, rx_end, rx_crc_ok, remote_valid, remote_end;
    logic [7:0] rx_data, remote_data, tx_data, fwd_data, net_data, net_node;
    logic tx_valid, tx_last, fwd_valid, fwd_last, net_valid, net_last, local_req, access_wide;
    logic [1:0] fwd_slot, access_type;
    logic [15:0] access_base, access_count;
    int err_count = 0, n_tests = 0, n_local, n_fwd_last, n_net_last, n_bytes;

    msrta_core u_msrta_core (.core_clk(core_clk), .sys_rst(sys_rst), .own_node(8'h08),
        .downstream_mode(downstream_mode), .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end),
        .rx_crc_ok(rx_crc_ok), .remote_data(remote_data), .remote_valid(remote_valid),
        .remote_end(remote_end), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .fwd_data(fwd_data), .fwd_valid(fwd_valid), .fwd_last(fwd_last), .fwd_slot(fwd_slot),
        .net_data(net_data), .net_valid(net_valid), .net_last(net_last), .net_node(net_node),
        .local_req(local_req), .access_type(access_type), .access_base(access_base),
        .access_count(access_count), .access_wide(access_wide));
    msrta_master_model u_msrta_master_model (.core_clk(core_clk), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // pulse counters, cleared by each scenario; sampled mid-cycle so no launch-edge race
    always @(negedge core_clk)
    begin
        n_local += (local_req === 1'b1);
        n_bytes += (fwd_valid === 1'b1);
        n_bytes += (net_valid === 1'b1);
        n_fwd_last += (fwd_last === 1'b1);
        n_net_last += (net_last === 1'b1);
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : check

    task automatic clear_obs();
        u_msrta_master_model.resp.delete();
        n_local = 0;
        n_fwd_last = 0;
        n_net_last = 0;
        n_bytes = 0;
        u_msrta_master_model.n_last = 0;
    endtask : clear_obs

    // fixed wait long enough for the slowest answer
    task automatic settle();
        repeat (14) @(negedge core_clk);
    endtask : settle

    task automatic check_resp(input logic [7:0] e[$]);
        logic [15:0] c;
        c = u_msrta_master_model.crc16(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        check(16'(u_msrta_master_model.resp.size()), 16'(e.size()));
        foreach (e[i])
        begin
            if (i < u_msrta_master_model.resp.size())
            begin
                check({8'h00, u_msrta_master_model.resp[i]}, {8'h00, e[i]});
            end
        end
    endtask : check_resp

    task automatic t_local();
        clear_obs();
        u_msrta_master_model.send('{8'h08, 8'h40, 8'h00, 8'h00, 8'h01, 8'h00, 8'h07, 8'haa}, 1'b1);
        settle();
        check(16'(n_local), 16'h0001);
        check(16'(u_msrta_master_model.resp.size()), 16'h0000);
    endtask : t_local

    // int16, int32 and float selectors on the same parameter, count halved when wide
    task automatic t_types();
        for (int ty = 0; ty < 3; ty++)
        begin
            clear_obs();
            u_msrta_master_model.send('{8'h08, 8'h03, {2'(ty), 6'h00}, 8'hc8, 8'h00, 8'h08}, 1'b1);
            settle();
            check({14'h0000, access_type}, 16'(ty));
            check(access_base, 16'h00c8);
            check(access_count, (ty == 0) ? 16'h0008 : 16'h0004);
            check({15'h0000, access_wide}, (ty == 0) ? 16'h0000 : 16'h0001);
            check(16'(n_local), 16'h0001);
        end
    endtask : t_types

    task automatic t_exc(input logic [7:0] fc, input logic [7:0] ahi, input logic [7:0] cnt, input logic [7:0] code);
        clear_obs();
        u_msrta_master_model.send('{8'h08, fc, ahi, 8'hc8, 8'h00, cnt}, 1'b1);
        settle();
        check_resp('{8'h08, fc | 8'h80, code});
        check(16'(u_msrta_master_model.n_last), 16'h0001);
        check(16'(n_local), 16'h0000);
    endtask : t_exc

    // foreign node, global node and a corrupted frame give nothing back
    task automatic t_ignore();
        clear_obs();
        u_msrta_master_model.send('{8'h09, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01}, 1'b1);
        settle();
        u_msrta_master_model.send('{8'h00, 8'h05, 8'h00, 8'h01, 8'h00, 8'h01}, 1'b1);
        settle();
        u_msrta_master_model.send('{8'h08, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01}, 1'b0);
        settle();
        check(16'(u_msrta_master_model.resp.size()), 16'h0000);
        check(16'(n_local), 16'h0000);
    endtask : t_ignore

    // first pass decides, the replayed copy is routed on
    task automatic t_route(input logic [7:0] port, input logic [7:0] sub);
        logic [7:0] f[$];
        f = '{8'h08, 8'h40, port, sub, 8'h01, 8'h00, 8'h07, 8'h33};
        clear_obs();
        u_msrta_master_model.send(f, 1'b1);
        repeat (4) @(negedge core_clk);
        u_msrta_master_model.send(f, 1'b1);
        settle();
        check(16'(n_local), 16'h0000);
    endtask : t_route

    task automatic t_forward();
        for (int p = 1; p < 4; p++)
        begin
            t_route(8'(p), 8'h00);
            check(16'(n_fwd_last), 16'h0001);
            check(16'(n_bytes), 16'h000a);
            check({14'h0000, fwd_slot}, 16'(p));
            check(16'(u_msrta_master_model.resp.size()), 16'h0000);
        end
    endtask : t_forward

    task automatic t_downstream();
        logic [7:0] r[$];
        r = '{8'h05, 8'h40, 8'h00, 8'h00, 8'h02, 8'h00, 8'h07, 8'h44};
        downstream_mode = 1'b1;
        t_route(8'h00, 8'h05);
        check(16'(n_net_last), 16'h0001);
        check({8'h00, net_node}, 16'h0005);
        check(16'(n_bytes), 16'h0006);
        check({8'h00, net_data}, 16'h0033);
        foreach (r[i])
        begin
            @(negedge core_clk);
            remote_data = r[i];
            remote_valid = 1'b1;
        end
        @(negedge core_clk);
        remote_valid = 1'b0;
        remote_data = ~remote_data;
        remote_end = 1'b1;
        @(negedge core_clk);
        remote_end = 1'b0;
        settle();
        check_resp(r);
        clear_obs();
        u_msrta_master_model.send('{8'h08, 8'h40, 8'h00, 8'h00, 8'h01, 8'h00, 8'h07}, 1'b1);
        settle();
        check(16'(n_local), 16'h0001);
        downstream_mode = 1'b0;
    endtask : t_downstream

    task automatic report_and_stop();
        if (err_count == 0 && n_tests > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    initial
    begin
        #500000;
        err_count++;
        report_and_stop();
    end

    initial
    begin
        sys_rst = 1'b1;
        downstream_mode = 1'b0;
        remote_data = 8'h00;
        remote_valid = 1'b0;
        remote_end = 1'b0;
        repeat (4) @(negedge core_clk);
        sys_rst = 1'b0;
        t_local();
        t_types();
        t_exc(8'h03, 8'h40, 8'h03, MSRTA_EXC_RANGE);
        t_exc(8'h03, 8'hc0, 8'h02, MSRTA_EXC_RANGE);
        t_exc(8'h05, 8'h00, 8'h02, MSRTA_EXC_FUNC);
        t_ignore();
        t_forward();
        t_downstream();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
